/* File: verilog/bir_params.svh */
// Offsets, field positions, reset values and counts of the interrupt router
`ifndef BIR_PARAMS_SVH
`define BIR_PARAMS_SVH
`define BIR_OFF_NSTAT 8'h00
`define BIR_OFF_ESTAT 8'h04
`define BIR_OFF_NEN 8'h08
`define BIR_OFF_EEN 8'h0C
`define BIR_OFF_DIR 8'h10
`define BIR_OFF_MAP 8'h20
`define BIR_OFF_MBOX 8'h40
`define BIR_OFF_DMA 8'h60
`define BIR_NUM_MAP 7
`define BIR_NUM_MBOX 8
`define BIR_NUM_DMA 4
`define BIR_NUM_PIN 8
`define BIR_NUM_NSRC 30
`define BIR_NUM_ESRC 24
`define BIR_NUM_SRC 54
`define BIR_NB_HOST 0
`define BIR_NB_IOP 1
`define BIR_NB_DMA 2
`define BIR_NB_HW 6
`define BIR_NB_DB 14
`define BIR_NB_MBOX 22
`define BIR_NEN_RST 30'h0000_0001
`define BIR_DB_FIELD 30'h003F_C000
`define BIR_DMA_EN_LSB 8
`define BIR_FILT_SAMPLES 3
`endif

/* File: verilog/bir_pkg.sv */
// Shared types of the interrupt router
package bir_pkg;
    typedef struct packed {
        logic done;
        logic p1Fault;
        logic p2Fault;
        logic pbFault;
        logic halt;
        logic stop;
    } bir_dma_ev_t;

    typedef struct packed {
        logic [5:0] enable;
        logic [5:0] status;
    } bir_dma_csr_t;
endpackage : bir_pkg

/* File: verilog/bir_pin_filter.sv */
// Two-stage synchroniser and low-level filter for the interrupt pins
`timescale 1ns/1ps
`include "bir_params.svh"
module bir_pin_filter #(
    parameter int WIDTH = `BIR_NUM_PIN,
    parameter int SAMPLES = `BIR_FILT_SAMPLES
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] lowSeen
);
    localparam int CW = $clog2(SAMPLES + 1);
    logic [WIDTH-1:0] syncA, syncB, next_lowSeen;
    logic [WIDTH-1:0][CW-1:0] lowCnt, next_lowCnt;

    always_comb begin
        for (int p = 0; p < WIDTH; p++) begin
            if (syncB[p]) begin
                next_lowCnt[p] = '0;
            end else if (lowCnt[p] == CW'(SAMPLES)) begin
                next_lowCnt[p] = lowCnt[p];
            end else begin
                next_lowCnt[p] = lowCnt[p] + CW'(1);
            end
            next_lowSeen[p] = (next_lowCnt[p] == CW'(SAMPLES));
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            syncA <= '1;
            syncB <= '1;
            lowCnt <= '0;
            lowSeen <= '0;
        end else begin
            syncA <= pinIn;
            syncB <= syncA;
            lowCnt <= next_lowCnt;
            lowSeen <= next_lowSeen;
        end
    end

    for (genvar p = 0; p < WIDTH; p++) begin : gChk
        AST_THREE_LOW_SAMPLES: assert property (@(posedge mclk) disable iff (srst)
            $rose(lowSeen[p]) |-> !$past(syncB[p], 1) && !$past(syncB[p], 2)
                && !$past(syncB[p], 3))
            else $error("pin flagged before three low samples");
    end
endmodule : bir_pin_filter

/* File: verilog/bir_dma_chan.sv */
// Per-channel DMA interrupt causes with enables and restart interlock
`timescale 1ns/1ps
`include "bir_params.svh"
module bir_dma_chan import bir_pkg::*; (
    input wire logic mclk,
    input wire logic srst,
    input wire logic csrWrite,
    input wire logic [31:0] wdata,
    input bir_dma_ev_t causeEv,
    output logic [31:0] rdata,
    output logic irq,
    output logic restartOk
);
    bir_dma_csr_t csr, next_csr;

    always_comb begin
        next_csr = csr;
        if (csrWrite) begin
            next_csr.enable = wdata[`BIR_DMA_EN_LSB +: 6];
            next_csr.status = csr.status & ~wdata[5:0];
        end
        // A cause arriving with its clear survives
        next_csr.status = next_csr.status | causeEv;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            csr <= '0;
            restartOk <= 1'b1;
        end else begin
            csr <= next_csr;
            restartOk <= (next_csr.status == 6'h00);
        end
    end

    assign irq = |(csr.status & csr.enable);
    assign rdata = {18'h00000, csr.enable, 2'h0, csr.status};

    AST_NO_RESTART_PENDING: assert property (@(posedge mclk) disable iff (srst)
        (csr.status != 6'h00) |-> !restartOk)
        else $error("channel restart allowed with cause pending");
endmodule : bir_dma_chan

/* File: verilog/bir_router.sv */
// Interrupt enable, status, routing, pin and mailbox logic behind APB
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "bir_params.svh"
module bir_router import bir_pkg::*; (
    input wire logic mclk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [`BIR_NUM_PIN-1:0] pinIn,
    output logic [`BIR_NUM_PIN-1:0] pinOut,
    output logic [`BIR_NUM_PIN-1:0] pinOe,
    input wire logic hostPostPending,
    input wire logic iopPostEvent,
    input bir_dma_ev_t [`BIR_NUM_DMA-1:0] dmaEvent,
    input wire logic [`BIR_NUM_ESRC-1:0] errEvent,
    output logic [`BIR_NUM_DMA-1:0] dmaRestartOk
);
    // ****************************************************************
    // Bus decode
    // ****************************************************************
    function automatic logic inWin(input logic [7:0] a, input logic [7:0] base, input int n);
        return (a >= base) && (a < base + 8'(4 * n)) && (a[1:0] == 2'h0);
    endfunction : inWin

    logic acc, wr, rdStart, hitMap, hitMbox, hitDma;
    logic [2:0] wi;
    assign acc = psel & penable & pready;
    assign wr = acc & pwrite;
    assign rdStart = psel & penable & ~pready;
    assign wi = paddr[4:2];
    assign hitMap = inWin(paddr, `BIR_OFF_MAP, `BIR_NUM_MAP);
    assign hitMbox = inWin(paddr, `BIR_OFF_MBOX, `BIR_NUM_MBOX);
    assign hitDma = inWin(paddr, `BIR_OFF_DMA, `BIR_NUM_DMA);

    // ****************************************************************
    // State
    // ****************************************************************
    logic [`BIR_NUM_NSRC-1:0] normEn, next_normEn, normStat, next_normStat;
    logic [`BIR_NUM_NSRC-1:0] normSet, normClr, normGate;
    logic [`BIR_NUM_ESRC-1:0] errEn, next_errEn, errStat, next_errStat, errClr;
    logic [`BIR_NUM_PIN-1:0] pinDir, next_pinDir, lowSeen, want, next_pinOe, next_pinOut;
    logic [`BIR_NUM_MAP-1:0][23:0] mapReg, next_mapReg;
    logic [`BIR_NUM_MBOX-1:0][31:0] mbox, next_mbox;
    logic [`BIR_NUM_DMA-1:0] chanIrq, dmaIrqQ, next_dmaIrqQ, dmaWr;
    logic [`BIR_NUM_DMA-1:0][31:0] dmaRd;
    logic [`BIR_NUM_SRC-1:0] act;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;

    // ****************************************************************
    // Submodules
    // ****************************************************************
    bir_pin_filter #(.WIDTH(`BIR_NUM_PIN), .SAMPLES(`BIR_FILT_SAMPLES)) uFilt (
        .mclk(mclk),
        .srst(srst),
        .pinIn(pinIn),
        .lowSeen(lowSeen)
    );

    for (genvar c = 0; c < `BIR_NUM_DMA; c++) begin : gChan
        assign dmaWr[c] = wr && hitDma && (paddr[3:2] == 2'(c));
        bir_dma_chan uChan (
            .mclk(mclk),
            .srst(srst),
            .csrWrite(dmaWr[c]),
            .wdata(pwdata),
            .causeEv(dmaEvent[c]),
            .rdata(dmaRd[c]),
            .irq(chanIrq[c]),
            .restartOk(dmaRestartOk[c])
        );
    end

    // ****************************************************************
    // APB slave, one wait state on every access
    // ****************************************************************
    always_comb begin
        next_pready = rdStart;
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        if (rdStart) begin
            if (paddr == `BIR_OFF_NSTAT) begin
                next_prdata = {|errStat, 1'b0, normStat};
            end else if (paddr == `BIR_OFF_ESTAT) begin
                next_prdata = {|normStat, 7'h00, errStat};
            end else if (paddr == `BIR_OFF_NEN) begin
                next_prdata = {2'h0, normEn};
            end else if (paddr == `BIR_OFF_EEN) begin
                next_prdata = {8'h00, errEn};
            end else if (paddr == `BIR_OFF_DIR) begin
                next_prdata = {24'h000000, pinDir};
            end else if (hitMap) begin
                next_prdata = {8'h00, mapReg[wi]};
            end else if (hitMbox) begin
                next_prdata = mbox[wi];
            end else if (hitDma) begin
                next_prdata = dmaRd[paddr[3:2]];
            end else begin
                next_pslverr = 1'b1;
            end
            if (pwrite) begin
                next_prdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= next_pready;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // ****************************************************************
    // Configuration: enables, direction, maps, mailboxes
    // ****************************************************************
    always_comb begin
        next_normEn = normEn;
        next_errEn = errEn;
        next_pinDir = pinDir;
        next_mapReg = mapReg;
        next_mbox = mbox;
        if (wr) begin
            // Doorbell bits only ring, they are not stored
            if (paddr == `BIR_OFF_NEN) begin
                next_normEn = pwdata[`BIR_NUM_NSRC-1:0] & ~`BIR_DB_FIELD;
            end
            if (paddr == `BIR_OFF_EEN) begin
                next_errEn = pwdata[`BIR_NUM_ESRC-1:0];
            end
            if (paddr == `BIR_OFF_DIR) begin
                next_pinDir = pwdata[`BIR_NUM_PIN-1:0];
            end
            if (hitMap) begin
                next_mapReg[wi] = pwdata[23:0];
            end
            if (hitMbox) begin
                next_mbox[wi] = pwdata;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            normEn <= `BIR_NEN_RST;
            errEn <= '0;
            pinDir <= '0;
            mapReg <= '0;
            mbox <= '0;
        end else begin
            normEn <= next_normEn;
            errEn <= next_errEn;
            pinDir <= next_pinDir;
            mapReg <= next_mapReg;
            mbox <= next_mbox;
        end
    end

    // ****************************************************************
    // Status: hardware set beats a software clear in the same cycle
    // ****************************************************************
    always_comb begin
        normSet = '0;
        normClr = '0;
        errClr = '0;
        normSet[`BIR_NB_IOP] = iopPostEvent;
        normSet[`BIR_NB_DMA +: `BIR_NUM_DMA] = chanIrq & ~dmaIrqQ;
        // Pins driven as outputs must not flag themselves
        normSet[`BIR_NB_HW +: `BIR_NUM_PIN] = lowSeen & ~pinDir;
        if (wr && paddr == `BIR_OFF_NEN) begin
            normSet[`BIR_NB_DB +: 8] = pwdata[`BIR_NB_DB +: 8];
        end
        if (wr && hitMbox) begin
            normSet[`BIR_NB_MBOX +: `BIR_NUM_MBOX] = 8'h01 << wi;
        end
        if (wr && paddr == `BIR_OFF_NSTAT) begin
            normClr = pwdata[`BIR_NUM_NSRC-1:0];
        end
        if (wr && paddr == `BIR_OFF_ESTAT) begin
            errClr = pwdata[`BIR_NUM_ESRC-1:0];
        end
        next_normStat = (normStat & ~normClr) | normSet;
        // Host queue bit follows the queue, it cannot be cleared
        next_normStat[`BIR_NB_HOST] = hostPostPending;
        next_errStat = (errStat & ~errClr) | errEvent;
        next_dmaIrqQ = chanIrq;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            normStat <= '0;
            errStat <= '0;
            dmaIrqQ <= '0;
        end else begin
            normStat <= next_normStat;
            errStat <= next_errStat;
            dmaIrqQ <= next_dmaIrqQ;
        end
    end

    // ****************************************************************
    // Routing onto open-drain pins
    // ****************************************************************
    always_comb begin
        normGate = normEn | `BIR_DB_FIELD;
        normGate[`BIR_NB_HOST] = ~normEn[`BIR_NB_HOST];
        act = {errStat & errEn, normStat & normGate};
        want = '0;
        for (int s = 0; s < `BIR_NUM_SRC; s++) begin
            // OR of all sources: a shared pin stays low until every one drops
            if (act[s]) begin
                want[mapReg[s / 8][(s % 8) * 3 +: 3]] = 1'b1;
            end
        end
        next_pinOe = pinDir & want;
        next_pinOut = '0;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            pinOe <= '0;
            pinOut <= '0;
        end else begin
            pinOe <= next_pinOe;
            pinOut <= next_pinOut;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_ENABLES_CLEAR: assert property (@(posedge mclk) disable iff (srst)
        $fell(srst) |-> (normEn[`BIR_NUM_NSRC-1:1] == '0) && (errEn == '0) && (pinOe == '0))
        else $error("enables not clear after reset");
    AST_PIN_NEVER_HIGH: assert property (@(posedge mclk) disable iff (srst)
        pinOut == '0)
        else $error("interrupt pin driven high");
    AST_INPUT_PIN_QUIET: assert property (@(posedge mclk) disable iff (srst)
        (pinOe & ~$past(pinDir)) == '0)
        else $error("input pin driven");
    AST_PIN_NEEDS_SOURCE: assert property (@(posedge mclk) disable iff (srst)
        (pinOe != '0) |-> ($past(act) != '0))
        else $error("pin low with no enabled source");
    AST_DOORBELL_RING: assert property (@(posedge mclk) disable iff (srst)
        (wr && paddr == `BIR_OFF_NEN && pwdata[`BIR_NB_DB]) |=> normStat[`BIR_NB_DB])
        else $error("doorbell not rung");
    AST_DOORBELL_CLEAR: assert property (@(posedge mclk) disable iff (srst)
        (wr && paddr == `BIR_OFF_NSTAT && pwdata[`BIR_NB_DB]) |=> !normStat[`BIR_NB_DB])
        else $error("doorbell not cleared");
    AST_MAILBOX_RAISE: assert property (@(posedge mclk) disable iff (srst)
        (wr && paddr == `BIR_OFF_MBOX) |=> normStat[`BIR_NB_MBOX] && (mbox[0] == $past(pwdata)))
        else $error("mailbox write did not flag");
    AST_ERR_W1C: assert property (@(posedge mclk) disable iff (srst)
        (wr && paddr == `BIR_OFF_ESTAT && pwdata[0] && !errEvent[0]) |=> !errStat[0])
        else $error("error status not cleared");
    AST_STATUS_RESET: assert property (@(posedge mclk) disable iff (srst)
        $fell(srst) |-> (normStat == '0) && (errStat == '0))
        else $error("status not clear after reset");
    AST_PINS_INPUT_RESET: assert property (@(posedge mclk) disable iff (srst)
        $fell(srst) |-> (pinDir == '0))
        else $error("pin not an input after reset");
    AST_IOP_QUEUE_SET: assert property (@(posedge mclk) disable iff (srst)
        iopPostEvent |=> normStat[`BIR_NB_IOP])
        else $error("IO-processor queue status not set");
    AST_READY_ONE_CYCLE: assert property (@(posedge mclk) disable iff (srst)
        pready |=> !pready)
        else $error("ready held longer than one cycle");
endmodule : bir_router

/* File: test/bir_pin_model.sv */
// Open-drain interrupt wires with pull-ups and outside agents that pull them low
`timescale 1ns/1ps
module bir_pin_model (
    input wire logic [7:0] devOe,
    input wire logic [7:0] extPull,
    output logic [7:0] wireLevel
);
    // ************************************************************
    // Wire level
    // ************************************************************
    // A released line floats up to the pull-up, so no party ever drives it high
    assign wireLevel = ~(devOe | extPull);
endmodule : bir_pin_model

/* File: test/bir_router_bench.sv */
// Register-level tests of the interrupt router over APB
`timescale 1ns/1ps
`include "bir_params.svh"
module bir_router_bench import bir_pkg::*; ();
    logic mclk = 1'h0;
    logic srst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] pinIn;
    logic [7:0] pinOut;
    logic [7:0] pinOe;
    logic [7:0] extPull = 8'h00;
    logic hostPostPending = 1'h0;
    logic iopPostEvent = 1'h0;
    bir_dma_ev_t [3:0] dmaEvent = '0;
    logic [23:0] errEvent = 24'h0;
    logic [3:0] dmaRestartOk;
    logic [31:0] rd;
    logic err;
    int badCount = 0;
    int testsRun = 0;

    always #4 mclk = ~mclk;

    bir_router dut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut),
        .pinOe(pinOe), .hostPostPending(hostPostPending), .iopPostEvent(iopPostEvent),
        .dmaEvent(dmaEvent), .errEvent(errEvent), .dmaRestartOk(dmaRestartOk));

    bir_pin_model pins (.devOe(pinOe), .extPull(extPull), .wireLevel(pinIn));

    // ************************************************************
    // Bus and check tasks
    // ************************************************************
    task automatic testDone();
        if (badCount == 0 && testsRun > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : testDone

    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            badCount++;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    endtask : chkWord

    task automatic chkPins(input logic [7:0] got, input logic [7:0] exp);
        testsRun++;
        if (got !== exp) begin
            badCount++;
            $display("BAD %0t pins %h expected %h", $time, got, exp);
        end
    endtask : chkPins

    // Request held until pready is sampled high; no fixed wait assumed
    task automatic apbXfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 20) begin
            badCount++;
            $display("BAD %0t no pready", $time);
        end
    endtask : apbXfer

    task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
        apbXfer(1'h1, a, d);
    endtask : wrReg

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        apbXfer(1'h0, a, 32'h0);
        chkWord(rd, exp);
    endtask : rdChk

    // Pin enables follow status and enables a cycle late
    task automatic settle();
        repeat (3) @(posedge mclk);
        #1;
    endtask : settle

    task automatic pulse(input logic [23:0] e, input logic [5:0] dm, input logic iop);
        @(posedge mclk);
        errEvent <= e;
        dmaEvent[0] <= bir_dma_ev_t'(dm);
        iopPostEvent <= iop;
        @(posedge mclk);
        errEvent <= 24'h0;
        dmaEvent[0] <= '0;
        iopPostEvent <= 1'h0;
    endtask : pulse

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        #200000;
        badCount++;
        testDone();
    end

    initial begin
        repeat (6) @(posedge mclk);
        srst <= 1'h0;
        rdChk(`BIR_OFF_NSTAT, 32'h0);
        rdChk(`BIR_OFF_NEN, 32'h1);
        rdChk(`BIR_OFF_EEN, 32'h0);
        rdChk(`BIR_OFF_DIR, 32'h0);
        chkWord({28'h0, dmaRestartOk}, 32'hF);
        wrReg(8'hF0, 32'hFFFF_FFFF);
        rdChk(8'hF2, 32'h0);
        chkWord({31'h0, err}, 32'h1);
        for (int i = 0; i < 24; i++) begin
            pulse(24'h1 << i, 6'h0, 1'h0);
            rdChk(`BIR_OFF_ESTAT, 32'h1 << i);
            wrReg(`BIR_OFF_ESTAT, 32'h1 << i);
        end
        rdChk(`BIR_OFF_ESTAT, 32'h0);
        // Error source 0 is map source 30: register 3, field 6
        pulse(24'h1, 6'h0, 1'h0);
        wrReg(`BIR_OFF_EEN, 32'h1);
        settle();
        chkPins(pinOe, 8'h00);
        wrReg(`BIR_OFF_DIR, 32'hFF);
        rdChk(`BIR_OFF_NSTAT, 32'h8000_0000);
        for (int c = 0; c < 8; c++) begin
            wrReg(8'h2C, 32'(c) << 18);
            settle();
            chkPins(pinOe, 8'h01 << c);
        end
        chkPins(pinOut, 8'h00);
        wrReg(`BIR_OFF_EEN, 32'h0);
        settle();
        chkPins(pinOe, 8'h00);
        wrReg(`BIR_OFF_ESTAT, 32'h1);
        wrReg(8'h2C, 32'h0);
        // Doorbell 0 and mailbox 0 share pin 0
        wrReg(`BIR_OFF_NEN, 32'h0040_4001);
        rdChk(`BIR_OFF_NEN, 32'h0040_0001);
        wrReg(`BIR_OFF_MBOX, 32'hA5C3_0F96);
        rdChk(`BIR_OFF_NSTAT, 32'h0040_4000);
        settle();
        chkPins(pinOe, 8'h01);
        wrReg(`BIR_OFF_NSTAT, 32'h0000_4000);
        settle();
        chkPins(pinOe, 8'h01);
        wrReg(`BIR_OFF_NSTAT, 32'h0040_0000);
        settle();
        chkPins(pinOe, 8'h00);
        wrReg(`BIR_OFF_NEN, 32'h1);
        rdChk(`BIR_OFF_NSTAT, 32'h0);
        for (int m = 0; m < 8; m++) begin
            wrReg(`BIR_OFF_MBOX + 8'(4 * m), 32'h1357_9BDF ^ 32'(m));
        end
        for (int m = 0; m < 8; m++) begin
            rdChk(`BIR_OFF_MBOX + 8'(4 * m), 32'h1357_9BDF ^ 32'(m));
        end
        rdChk(`BIR_OFF_NSTAT, 32'h3FC0_0000);
        wrReg(`BIR_OFF_NSTAT, 32'h3FC0_0000);
        // General pin 2 as input: two low samples ignored, three flag it
        wrReg(`BIR_OFF_DIR, 32'h0);
        @(posedge mclk);
        extPull <= 8'h04;
        repeat (2) @(posedge mclk);
        extPull <= 8'h00;
        settle();
        rdChk(`BIR_OFF_NSTAT, 32'h0);
        extPull <= 8'h04;
        repeat (3) @(posedge mclk);
        extPull <= 8'h00;
        settle();
        rdChk(`BIR_OFF_NSTAT, 32'h100);
        wrReg(`BIR_OFF_NSTAT, 32'h100);
        rdChk(`BIR_OFF_NSTAT, 32'h0);
        // Host queue bit masks, IO-processor queue bit enables
        wrReg(`BIR_OFF_DIR, 32'h01);
        @(posedge mclk);
        hostPostPending <= 1'h1;
        settle();
        chkPins(pinOe, 8'h00);
        rdChk(`BIR_OFF_NSTAT, 32'h1);
        wrReg(`BIR_OFF_NEN, 32'h0);
        settle();
        chkPins(pinOe, 8'h01);
        @(posedge mclk);
        hostPostPending <= 1'h0;
        pulse(24'h0, 6'h0, 1'h1);
        settle();
        chkPins(pinOe, 8'h00);
        wrReg(`BIR_OFF_NEN, 32'h2);
        settle();
        chkPins(pinOe, 8'h01);
        wrReg(`BIR_OFF_NSTAT, 32'h2);
        settle();
        chkPins(pinOe, 8'h00);
        // Every cause of channel 0 in turn, routed to pin 0
        wrReg(`BIR_OFF_NEN, 32'h4);
        wrReg(`BIR_OFF_DMA, 32'h3F00);
        for (int k = 0; k < 6; k++) begin
            pulse(24'h0, 6'h1 << k, 1'h0);
            rdChk(`BIR_OFF_DMA, 32'h3F00 | (32'h1 << k));
            chkWord({28'h0, dmaRestartOk}, 32'hE);
            wrReg(`BIR_OFF_DMA, 32'h3F00 | (32'h1 << k));
            settle();
            chkWord({28'h0, dmaRestartOk}, 32'hF);
        end
        chkPins(pinOe, 8'h01);
        rdChk(`BIR_OFF_NSTAT, 32'h4);
        wrReg(`BIR_OFF_NSTAT, 32'h4);
        settle();
        chkPins(pinOe, 8'h00);
        // Last channel: done cause blocks restart until cleared
        wrReg(`BIR_OFF_DMA + 8'h0C, 32'h2000);
        @(posedge mclk);
        dmaEvent[3] <= bir_dma_ev_t'(6'h20);
        @(posedge mclk);
        dmaEvent[3] <= '0;
        rdChk(`BIR_OFF_DMA + 8'h0C, 32'h2020);
        chkWord({28'h0, dmaRestartOk}, 32'h7);
        rdChk(`BIR_OFF_NSTAT, 32'h20);
        wrReg(`BIR_OFF_DMA + 8'h0C, 32'h2020);
        wrReg(`BIR_OFF_NSTAT, 32'h20);
        settle();
        chkWord({28'h0, dmaRestartOk}, 32'hF);
        rdChk(`BIR_OFF_NSTAT, 32'h0);
        testDone();
    end
endmodule : bir_router_bench
